/* verilog/ubfc_core.sv */
`timescale 1ns/1ps
module ubfc_core #(
   parameter bit HAS_MODEM = 1'b1
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic periph_en,
   // Configuration, read live even while the clock is stopped
   input wire logic [1:0] baud_clock_source_select,
   input wire logic [15:0] clock_divisor,
   input wire logic sync_mode,
   input wire logic over8,
   input wire logic [1:0] char_len,
   input wire logic mode9,
   input wire logic msb_first,
   input wire logic [2:0] parity_type,
   input wire logic [1:0] stop_bits,
   input wire logic [1:0] chan_mode,
   input wire logic handshake_en,
   input wire logic rts_request,
   input wire logic [7:0] timeout_val,
   input wire logic [7:0] timeguard_val,
   input wire logic dma_en,
   input wire logic status_clear,
   // Transmit data
   input wire logic tx_valid,
   input wire logic [8:0] tx_data,
   input wire logic tx_addr_mark,
   output logic tx_ready,
   // Receive data
   output logic rx_valid,
   output logic [8:0] rx_data,
   output logic rx_addr_mark,
   input wire logic rx_ready,
   // Status
   output logic parity_err,
   output logic frame_err,
   output logic overrun_err,
   output logic rx_timeout,
   output logic ring_indicator,
   output logic carrier_detect,
   // DMA requests
   output logic tx_dma_req,
   output logic rx_dma_req,
   // Serial pins
   input wire logic sck_in,
   output logic sck_out,
   output logic sck_oe,
   output logic txd_out,
   input wire logic rxd_in,
   input wire logic cts_n,
   output logic rts_n,
   input wire logic ring_indicator_in_n,
   input wire logic carrier_detect_in_n
);
   typedef struct packed {
      logic sck_prev;
      logic [4:0] os_cnt;
      ubfc_pkg::ubfc_rx_st_t rx_st;
      logic [4:0] rx_cnt;
      logic [3:0] rx_bit;
      logic [8:0] rx_sh;
      logic rx_pbit;
      logic [8:0] rx_data;
      logic rx_addr;
      logic rx_valid;
      logic par_err, frm_err, ovr_err, tmo, tmo_arm;
      logic [7:0] tmo_cnt;
      ubfc_pkg::ubfc_tx_st_t tx_st;
      logic [4:0] tx_cnt;
      logic [3:0] tx_bit;
      logic [8:0] tx_sh;
      logic tx_pbit;
      logic [7:0] tg_cnt;
      logic tx_line, txd, rts_n, sck_out, sck_oe;
      logic tx_dma, rx_dma, ring, carrier;
   } ubfc_core_st_t;
   ubfc_core_st_t q;
   ubfc_core_st_t d;
   logic pre_tick, src_tick, div_tick, div_in, ext_sync, sck_rise, samp, baud;
   logic [4:0] os;
   logic [5:0] stop_len;
   logic [3:0] nbits, tx_idx;
   logic [8:0] mask, rx_word;
   logic rx_in, rx_end, tx_end, par_none, rx_done, rx_bad_par, pop, fifo_valid;
   logic [9:0] fifo_word;

   // Parity bit of a masked character
   function automatic logic par_of(input logic [8:0] w, input logic [2:0] t, input logic a);
      case (t)
         ubfc_pkg::PAR_EVEN: par_of = ^w;
         ubfc_pkg::PAR_ODD: par_of = ~^w;
         ubfc_pkg::PAR_SPACE: par_of = 1'b0;
         ubfc_pkg::PAR_MARK: par_of = 1'b1;
         default: par_of = a;
      endcase
   endfunction

   // Fixed prescaler on the master clock
   ubfc_div u_pre (
      .mclk(mclk),
      .reset_n(reset_n),
      .tick_in(periph_en),
      .divisor(ubfc_pkg::PRESCALE),
      .tick_out(pre_tick)
   );

   // Pin clock edge, valid given slow pin clock
   assign sck_rise = periph_en && sck_in && !q.sck_prev;
   assign ext_sync = sync_mode && (baud_clock_source_select == ubfc_pkg::SRC_EXT);

   // Source select
   always_comb begin
      case (baud_clock_source_select)
         ubfc_pkg::SRC_MCK: src_tick = periph_en;
         ubfc_pkg::SRC_DIV: src_tick = pre_tick;
         ubfc_pkg::SRC_EXT: src_tick = sck_rise;
         default: src_tick = 1'b0;
      endcase
   end
   assign div_in = src_tick && !ext_sync;

   // Programmable divider
   ubfc_div u_baud (
      .mclk(mclk),
      .reset_n(reset_n),
      .tick_in(div_in),
      .divisor(clock_divisor),
      .tick_out(div_tick)
   );

   // Sample tick, oversampling and frame sizes
   assign samp = ext_sync ? sck_rise : div_tick;
   assign os = sync_mode ? ubfc_pkg::OS1 : (over8 ? ubfc_pkg::OS8 : ubfc_pkg::OS16);
   assign baud = samp && (q.os_cnt == os - 5'h01);
   assign nbits = mode9 ? ubfc_pkg::LEN_NINE : ubfc_pkg::LEN_BASE + {2'h0, char_len};
   assign mask = 9'h1FF >> (ubfc_pkg::LEN_NINE - nbits);
   assign par_none = (parity_type == ubfc_pkg::PAR_NONE);
   assign rx_end = (q.rx_cnt == os - 5'h01);
   assign tx_end = ({1'b0, q.tx_cnt} == stop_len - 6'h01) || (q.tx_st != ubfc_pkg::TX_STOP
      && q.tx_cnt == os - 5'h01);
   assign rx_in = (chan_mode == ubfc_pkg::CH_LOCAL) ? q.tx_line : rxd_in;
   assign rx_word = msb_first ? (q.rx_sh & mask) : (q.rx_sh >> (ubfc_pkg::LEN_NINE - nbits));
   assign rx_done = samp && (q.rx_st == ubfc_pkg::RX_STOP) && rx_end;
   assign rx_bad_par = !par_none && parity_type != ubfc_pkg::PAR_MULTI
      && q.rx_pbit != par_of(rx_word, parity_type, 1'b0);
   assign tx_idx = msb_first ? nbits - 4'h1 - q.tx_bit : q.tx_bit;

   // Stop length in sample ticks
   always_comb begin
      case (stop_bits)
         ubfc_pkg::STOP_15: stop_len = sync_mode ? {1'b0, os} : {1'b0, os} + {2'h0, os[4:1]};
         ubfc_pkg::STOP_2: stop_len = {os, 1'b0};
         default: stop_len = {1'b0, os};
      endcase
   end

   // Transmit buffer
   ubfc_fifo #(
      .WIDTH(ubfc_pkg::WORD_W),
      .DEPTH(ubfc_pkg::FIFO_DEPTH)
   ) u_fifo (
      .mclk(mclk),
      .reset_n(reset_n),
      .in_valid(tx_valid),
      .in_data({tx_addr_mark, tx_data}),
      .in_ready(tx_ready),
      .out_valid(fifo_valid),
      .out_data(fifo_word),
      .out_ready(pop)
   );

   // Next state
   always_comb begin
      d = q;
      pop = 1'b0;
      d.sck_prev = sck_in;
      if (status_clear) begin
         d.par_err = 1'b0;
         d.frm_err = 1'b0;
         d.ovr_err = 1'b0;
         d.tmo = 1'b0;
      end
      if (rx_ready) begin
         d.rx_valid = 1'b0;
      end
      if (samp) begin
         d.os_cnt = (q.os_cnt >= os - 5'h01) ? 5'h00 : q.os_cnt + 5'h01;
      end
      // Receiver
      if (samp) begin
         case (q.rx_st)
            ubfc_pkg::RX_IDLE: if (!rx_in) begin
               d.rx_cnt = 5'h00;
               d.rx_bit = 4'h0;
               d.rx_sh = 9'h000;
               d.rx_st = sync_mode ? ubfc_pkg::RX_DATA : ubfc_pkg::RX_START;
            end
            ubfc_pkg::RX_START: if (q.rx_cnt == {1'b0, os[4:1]}) begin
               d.rx_cnt = 5'h00;
               d.rx_st = rx_in ? ubfc_pkg::RX_IDLE : ubfc_pkg::RX_DATA;
            end else begin
               d.rx_cnt = q.rx_cnt + 5'h01;
            end
            ubfc_pkg::RX_DATA: if (rx_end) begin
               d.rx_cnt = 5'h00;
               d.rx_sh = msb_first ? {q.rx_sh[7:0], rx_in} : {rx_in, q.rx_sh[8:1]};
               d.rx_bit = q.rx_bit + 4'h1;
               if (q.rx_bit == nbits - 4'h1) begin
                  d.rx_st = par_none ? ubfc_pkg::RX_STOP : ubfc_pkg::RX_PAR;
               end
            end else begin
               d.rx_cnt = q.rx_cnt + 5'h01;
            end
            ubfc_pkg::RX_PAR: if (rx_end) begin
               d.rx_cnt = 5'h00;
               d.rx_pbit = rx_in;
               d.rx_st = ubfc_pkg::RX_STOP;
            end else begin
               d.rx_cnt = q.rx_cnt + 5'h01;
            end
            ubfc_pkg::RX_STOP: if (rx_end) begin
               d.rx_st = ubfc_pkg::RX_IDLE;
               d.rx_data = rx_word;
               d.rx_addr = (parity_type == ubfc_pkg::PAR_MULTI) && q.rx_pbit;
               d.rx_valid = 1'b1;
               d.tmo_arm = 1'b1;
               d.tmo_cnt = 8'h00;
               if (q.rx_valid && !rx_ready) d.ovr_err = 1'b1;
               if (!rx_in) d.frm_err = 1'b1;
               if (rx_bad_par) d.par_err = 1'b1;
            end else begin
               d.rx_cnt = q.rx_cnt + 5'h01;
            end
            default: d.rx_st = ubfc_pkg::RX_IDLE;
         endcase
      end
      // Idle time-out after a character
      if (baud && q.rx_st == ubfc_pkg::RX_IDLE && q.tmo_arm && timeout_val != 8'h00) begin
         if (q.tmo_cnt == timeout_val - 8'h01) begin
            d.tmo = 1'b1;
            d.tmo_arm = 1'b0;
         end else begin
            d.tmo_cnt = q.tmo_cnt + 8'h01;
         end
      end
      // Transmitter
      if (samp) begin
         d.tx_cnt = tx_end ? 5'h00 : q.tx_cnt + 5'h01;
         case (q.tx_st)
            ubfc_pkg::TX_IDLE: begin
               d.tx_cnt = 5'h00;
               if (fifo_valid && (!handshake_en || !cts_n)) begin
                  pop = 1'b1;
                  d.tx_sh = fifo_word[8:0] & mask;
                  d.tx_pbit = par_of(fifo_word[8:0] & mask, parity_type, fifo_word[9]);
                  d.tx_bit = 4'h0;
                  d.tx_line = 1'b0;
                  d.tx_st = ubfc_pkg::TX_START;
               end
            end
            ubfc_pkg::TX_START: if (tx_end) begin
               d.tx_line = q.tx_sh[tx_idx];
               d.tx_st = ubfc_pkg::TX_DATA;
            end
            ubfc_pkg::TX_DATA: if (tx_end) begin
               d.tx_bit = q.tx_bit + 4'h1;
               d.tx_line = msb_first ? q.tx_sh[tx_idx - 4'h1] : q.tx_sh[tx_idx + 4'h1];
               if (q.tx_bit == nbits - 4'h1) begin
                  d.tx_line = par_none ? 1'b1 : q.tx_pbit;
                  d.tx_st = par_none ? ubfc_pkg::TX_STOP : ubfc_pkg::TX_PAR;
               end
            end
            ubfc_pkg::TX_PAR: if (tx_end) begin
               d.tx_line = 1'b1;
               d.tx_st = ubfc_pkg::TX_STOP;
            end
            ubfc_pkg::TX_STOP: if (tx_end) begin
               d.tg_cnt = 8'h00;
               d.tx_st = (timeguard_val != 8'h00) ? ubfc_pkg::TX_GUARD : ubfc_pkg::TX_IDLE;
            end
            ubfc_pkg::TX_GUARD: if (baud) begin
               d.tg_cnt = q.tg_cnt + 8'h01;
               if (q.tg_cnt >= timeguard_val - 8'h01) d.tx_st = ubfc_pkg::TX_IDLE;
            end
            default: d.tx_st = ubfc_pkg::TX_IDLE;
         endcase
      end
      // Pin and request outputs
      case (chan_mode)
         ubfc_pkg::CH_ECHO, ubfc_pkg::CH_REMOTE: d.txd = rxd_in;
         ubfc_pkg::CH_LOCAL: d.txd = ubfc_pkg::LINE_IDLE;
         default: d.txd = q.tx_line;
      endcase
      d.rts_n = handshake_en ? d.rx_valid : !rts_request;
      d.sck_oe = sync_mode && !ext_sync;
      d.sck_out = sync_mode && !ext_sync && baud;
      d.tx_dma = dma_en && tx_ready;
      d.rx_dma = dma_en && d.rx_valid;
      d.ring = HAS_MODEM && !ring_indicator_in_n;
      d.carrier = HAS_MODEM && !carrier_detect_in_n;
      if (!periph_en) begin
         d = q;
      end
   end

   // State register
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         q <= '0;
         q.rx_st <= ubfc_pkg::RX_IDLE;
         q.tx_st <= ubfc_pkg::TX_IDLE;
         q.tx_line <= ubfc_pkg::LINE_IDLE;
         q.txd <= ubfc_pkg::LINE_IDLE;
         q.rts_n <= ubfc_pkg::RTS_N_RST;
      end else begin
         q <= d;
      end
   end

   // Outputs from flops
   assign rx_valid = q.rx_valid;
   assign rx_data = q.rx_data;
   assign rx_addr_mark = q.rx_addr;
   assign parity_err = q.par_err;
   assign frame_err = q.frm_err;
   assign overrun_err = q.ovr_err;
   assign rx_timeout = q.tmo;
   assign ring_indicator = q.ring;
   assign carrier_detect = q.carrier;
   assign tx_dma_req = q.tx_dma;
   assign rx_dma_req = q.rx_dma;
   assign sck_out = q.sck_out;
   assign sck_oe = q.sck_oe;
   assign txd_out = q.txd;
   assign rts_n = q.rts_n;

   // Checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);
   sequence s_bad_char;
      rx_done && rx_bad_par && !status_clear;
   endsequence
   sequence s_overrun;
      rx_done && q.rx_valid && !rx_ready && !status_clear;
   endsequence
   chk_div_zero_idle: assert property (
      clock_divisor == 16'h0000 |-> !div_tick) else $error("tick with zero divisor");
   chk_div_bypass: assert property (
      clock_divisor == 16'h0001 |-> div_tick == div_in) else $error("bypass not transparent");
   chk_prescale_gap: assert property (
      pre_tick |=> !pre_tick [*7]) else $error("prescaler faster than eight");
   chk_sync_ext_clock: assert property (
      ext_sync |-> samp == sck_rise && baud == sck_rise) else $error("pin clock divided");
   chk_parity_flag: assert property (
      s_bad_char |=> parity_err && rx_valid) else $error("parity error lost");
   chk_overrun_flag: assert property (
      s_overrun |=> overrun_err) else $error("overrun not flagged");
   chk_cts_holds_tx: assert property (
      handshake_en && cts_n && q.tx_st == ubfc_pkg::TX_IDLE |=> q.tx_st == ubfc_pkg::TX_IDLE)
      else $error("started against cts");
   chk_clock_freeze: assert property (
      !periph_en |=> $stable(q)) else $error("state moved while stopped");
   chk_local_loop_idle: assert property (
      periph_en && chan_mode == ubfc_pkg::CH_LOCAL |=> txd_out) else $error("local loop drives line");
   chk_echo_follows: assert property (
      periph_en && chan_mode == ubfc_pkg::CH_ECHO |=> txd_out == $past(rxd_in))
      else $error("echo wrong");
endmodule // ubfc_core

/* common/ubfc_pkg.sv */
package ubfc_pkg;
   // Baud source select codes
   localparam logic [1:0] SRC_MCK = 2'h0;
   localparam logic [1:0] SRC_DIV = 2'h1;
   localparam logic [1:0] SRC_EXT = 2'h3;
   localparam logic [15:0] PRESCALE = 16'h0008;
   // Parity codes
   localparam logic [2:0] PAR_EVEN = 3'h0;
   localparam logic [2:0] PAR_ODD = 3'h1;
   localparam logic [2:0] PAR_SPACE = 3'h2;
   localparam logic [2:0] PAR_MARK = 3'h3;
   localparam logic [2:0] PAR_NONE = 3'h4;
   localparam logic [2:0] PAR_MULTI = 3'h6;
   // Stop bit codes
   localparam logic [1:0] STOP_1 = 2'h0;
   localparam logic [1:0] STOP_15 = 2'h1;
   localparam logic [1:0] STOP_2 = 2'h2;
   // Channel modes
   localparam logic [1:0] CH_NORMAL = 2'h0;
   localparam logic [1:0] CH_ECHO = 2'h1;
   localparam logic [1:0] CH_LOCAL = 2'h2;
   localparam logic [1:0] CH_REMOTE = 2'h3;
   // Oversampling ratios and character lengths
   localparam logic [4:0] OS16 = 5'h10;
   localparam logic [4:0] OS8 = 5'h08;
   localparam logic [4:0] OS1 = 5'h01;
   localparam logic [3:0] LEN_BASE = 4'h5;
   localparam logic [3:0] LEN_NINE = 4'h9;
   // Data path sizes
   localparam int WORD_W = 10;
   localparam int FIFO_DEPTH = 4;
   // Reset levels
   localparam logic LINE_IDLE = 1'b1;
   localparam logic RTS_N_RST = 1'b1;
   // Frame state machines
   typedef enum logic [4:0] {
      RX_IDLE = 5'h01, RX_START = 5'h02, RX_DATA = 5'h04, RX_PAR = 5'h08, RX_STOP = 5'h10
   } ubfc_rx_st_t;
   typedef enum logic [5:0] {
      TX_IDLE = 6'h01, TX_START = 6'h02, TX_DATA = 6'h04,
      TX_PAR = 6'h08, TX_STOP = 6'h10, TX_GUARD = 6'h20
   } ubfc_tx_st_t;
   // Divider state
   typedef struct packed {
      logic [15:0] cnt;
   } ubfc_div_st_t;
endpackage

/* verilog/ubfc_div.sv */
`timescale 1ns/1ps
module ubfc_div (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // Tick in, divisor, tick out
   input wire logic tick_in,
   input wire logic [15:0] divisor,
   output logic tick_out
);
   ubfc_pkg::ubfc_div_st_t q;
   ubfc_pkg::ubfc_div_st_t d;

   // Count down, reload at terminal count
   always_comb begin
      d = q;
      tick_out = 1'b0;
      if (divisor == 16'h0000) begin
         d.cnt = 16'h0000;
      end else if (divisor == 16'h0001) begin
         tick_out = tick_in;
         d.cnt = 16'h0001;
      end else if (tick_in) begin
         if (q.cnt <= 16'h0001) begin
            tick_out = 1'b1;
            d.cnt = divisor;
         end else begin
            d.cnt = q.cnt - 16'h0001;
         end
      end
   end

   // State register
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end
endmodule // ubfc_div

/* verilog/ubfc_fifo.sv */
`timescale 1ns/1ps
module ubfc_fifo #(
   parameter int WIDTH = 10,
   parameter int DEPTH = 4
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // Fill side
   input wire logic in_valid,
   input wire logic [WIDTH-1:0] in_data,
   output logic in_ready,
   // Drain side
   output logic out_valid,
   output logic [WIDTH-1:0] out_data,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [CW-1:0] cnt;
      logic full;
      logic nempty;
   } ubfc_fifo_st_t;
   ubfc_fifo_st_t q;
   ubfc_fifo_st_t d;
   logic push;
   logic pop;

   // Handshakes from registered flags
   assign push = in_valid && !q.full;
   assign pop = out_ready && q.nempty;
   assign in_ready = !q.full;
   assign out_valid = q.nempty;
   assign out_data = q.mem[q.rp];

   // Pointer and count update
   always_comb begin
      d = q;
      if (push) begin
         d.mem[q.wp] = in_data;
         d.wp = q.wp + AW'(1);
      end
      if (pop) begin
         d.rp = q.rp + AW'(1);
      end
      if (push && !pop) begin
         d.cnt = q.cnt + CW'(1);
      end else if (pop && !push) begin
         d.cnt = q.cnt - CW'(1);
      end
      d.full = (d.cnt == CW'(DEPTH));
      d.nempty = (d.cnt != CW'(0));
   end

   // State register
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end
endmodule // ubfc_fifo

/* dv/ubfc_remote.sv */
`timescale 1ns/1ps
module ubfc_remote (
   // Master clock
   input wire logic mclk,
   // Serial lines
   input wire logic txd_out,
   output logic rxd_in,
   output logic sck_in,
   // Pin clock enable
   input wire logic sck_run
);
   int ph = 0;
   // No interrupt line reaches this side; level detection is the listener's own choice
   // Line rests high on its pull-up
   initial begin
      rxd_in = 1'b1;
      sck_in = 1'b0;
   end
   // Pin clock, three clocks high and three low, still when off
   always @(negedge mclk) begin
      ph <= sck_run ? (ph + 1) % 6 : 0;
      sck_in <= sck_run && ph > 2;
   end
   // Drive bits from bit 0 up, cyc clocks each, then idle high
   task automatic send(input logic [13:0] w, input int n, input int cyc);
      for (int i = 0; i < n; i++) begin
         @(negedge mclk);
         rxd_in = w[i];
         repeat (cyc - 1) @(negedge mclk);
      end
      @(negedge mclk);
      rxd_in = 1'b1;
   endtask
   // Capture n bits from a start bit, one per clock
   task automatic grab(input int n, output logic [13:0] w, output logic ok);
      int k;
      w = '0;
      for (k = 0; k < 1500 && txd_out !== 1'b0; k++) @(negedge mclk);
      ok = k < 1500;
      for (int i = 1; i < n; i++) begin
         @(negedge mclk);
         w[i] = txd_out;
      end
   endtask
endmodule // ubfc_remote

/* dv/usart_baud_and_frame_core_test.sv */
`timescale 1ns/1ps
module usart_baud_and_frame_core_test;
   // Stimulus
   logic mclk, reset_n, periph_en, sync_mode, over8, mode9, msb_first, handshake_en;
   logic rts_request, dma_en, status_clear, tx_valid, tx_addr_mark, rx_ready, cts_n;
   logic ring_indicator_in_n, carrier_detect_in_n, sck_run;
   logic [1:0] baud_clock_source_select, char_len, stop_bits, chan_mode;
   logic [15:0] clock_divisor;
   logic [2:0] parity_type;
   logic [7:0] timeout_val, timeguard_val;
   logic [8:0] tx_data, rx_data;
   // Observed
   logic tx_ready, rx_valid, rx_addr_mark, parity_err, frame_err, overrun_err, rx_timeout;
   logic ring_indicator, carrier_detect, tx_dma_req, rx_dma_req, sck_out, sck_oe;
   logic txd_out, rxd_in, sck_in, rts_n, ok;
   logic [13:0] v, got;
   int fail_count, n_compared, n, nb;
   typedef struct packed {
      logic [1:0] src;
      logic [15:0] cd;
      logic sy;
      logic o8;
      logic [7:0] len;
   } ubfc_rate_t;
   typedef struct packed {
      logic [1:0] cl;
      logic m9;
      logic msb;
      logic [2:0] par;
      logic [1:0] st;
      logic [8:0] d;
      logic am;
   } ubfc_fmt_t;
   ubfc_fmt_t e;
   // Source, divisor, mode, over8, start bit length in clocks
   ubfc_rate_t rates [6] = '{
      '{2'h0, 16'h0001, 1'b0, 1'b1, 8'h08}, '{2'h0, 16'h0003, 1'b0, 1'b0, 8'h30},
      '{2'h1, 16'h0001, 1'b0, 1'b1, 8'h40}, '{2'h0, 16'h0002, 1'b1, 1'b0, 8'h02},
      '{2'h3, 16'h0005, 1'b1, 1'b0, 8'h06}, '{2'h0, 16'h0000, 1'b1, 1'b0, 8'h00}};
   // Synchronous frame formats
   ubfc_fmt_t fmts [7] = '{
      '{2'h0, 1'b0, 1'b0, 3'h4, 2'h0, 9'h015, 1'b0},
      '{2'h1, 1'b0, 1'b1, 3'h0, 2'h2, 9'h02B, 1'b0},
      '{2'h2, 1'b0, 1'b0, 3'h1, 2'h1, 9'h05A, 1'b0},
      '{2'h3, 1'b0, 1'b1, 3'h2, 2'h0, 9'h0C3, 1'b0},
      '{2'h0, 1'b1, 1'b0, 3'h3, 2'h2, 9'h1A5, 1'b0},
      '{2'h3, 1'b0, 1'b0, 3'h6, 2'h3, 9'h081, 1'b1},
      '{2'h3, 1'b0, 1'b1, 3'h1, 2'h0, 9'h000, 1'b0}};

   ubfc_core uut (.*);
   ubfc_remote remote (.*);

   always #2 mclk = ~mclk;

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up;
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic stall;
      fail_count++;
      $display("ERROR t=%0t wait ran out", $time);
      wrap_up;
   endtask
   task automatic do_reset;
      reset_n = 1'b0;
      repeat (20) @(negedge mclk);
      chk({txd_out, rts_n, tx_ready, rx_valid, overrun_err, sck_oe}, 6'h38);
      reset_n = 1'b1;
   endtask
   task automatic cfg(input logic [1:0] s, input logic [15:0] cd, input logic sy, input logic o8);
      @(negedge mclk);
      {baud_clock_source_select, clock_divisor, sync_mode, over8} = {s, cd, sy, o8};
   endtask
   // Offer one word until the buffer takes it
   task automatic push(input logic [8:0] d, input logic am);
      int k;
      @(negedge mclk);
      {tx_valid, tx_data, tx_addr_mark} = {1'b1, d, am};
      for (k = 0; k < 2000 && tx_ready !== 1'b1; k++) @(negedge mclk);
      if (k == 2000) stall;
      @(negedge mclk);
      tx_valid = 1'b0;
   endtask
   // Wait for a character, compare it, consume it
   task automatic take(input logic [8:0] d, input logic am);
      int k;
      for (k = 0; k < 50 && rx_valid !== 1'b1; k++) @(negedge mclk);
      chk({rx_valid, rx_data, rx_addr_mark}, {1'b1, d, am});
      chk({rx_dma_req, parity_err, frame_err}, {dma_en, 2'h0});
      rx_ready = 1'b1;
      @(negedge mclk);
      rx_ready = 1'b0;
      chk(rx_valid, 0);
   endtask
   task automatic clr;
      @(negedge mclk);
      {rx_ready, status_clear} = 2'h3;
      @(negedge mclk);
      {rx_ready, status_clear} = 2'h0;
      @(negedge mclk);
   endtask
   // Clocks that the next start bit stays low, 0 if none comes
   task automatic start_len(output int len);
      int k;
      len = 0;
      for (k = 0; k < 1500 && txd_out !== 1'b0; k++) @(negedge mclk);
      while (k < 1500 && txd_out === 1'b0 && len < 300) begin
         @(negedge mclk);
         len++;
      end
   endtask
   // Expected line bits of a frame, start bit first; returns bit count
   function automatic int mk(input ubfc_fmt_t f, input int nd, output logic [13:0] w);
      int k;
      logic x;
      w = '0;
      k = 1;
      x = 1'b0;
      for (int i = 0; i < nd; i++) begin
         w[k] = f.msb ? f.d[nd - 1 - i] : f.d[i];
         x ^= f.d[i];
         k++;
      end
      if (f.par != ubfc_pkg::PAR_NONE) begin
         w[k] = f.par == ubfc_pkg::PAR_EVEN ? x : f.par == ubfc_pkg::PAR_ODD ? !x :
            f.par == ubfc_pkg::PAR_MARK ? 1'b1 : f.par == ubfc_pkg::PAR_MULTI ? f.am : 1'b0;
         k++;
      end
      w[k] = 1'b1;
      w[k + 1] = f.st == ubfc_pkg::STOP_2;
      return k + 1 + int'(f.st == ubfc_pkg::STOP_2);
   endfunction

   initial begin
      {mclk, reset_n, periph_en, sync_mode, over8, mode9, msb_first, handshake_en} = 8'h20;
      {rts_request, dma_en, status_clear, tx_valid, tx_addr_mark, rx_ready} = '0;
      {cts_n, ring_indicator_in_n, carrier_detect_in_n, sck_run} = 4'hE;
      {baud_clock_source_select, char_len, stop_bits, chan_mode} = '0;
      {clock_divisor, parity_type, timeout_val, timeguard_val, tx_data} = {16'h0001, 3'h4, 25'h0};
      fail_count = 0;
      n_compared = 0;
      do_reset;
      // Start bit length per source and divisor
      foreach (rates[i]) begin
         cfg(rates[i].src, rates[i].cd, rates[i].sy, rates[i].o8);
         sck_run = rates[i].src == ubfc_pkg::SRC_EXT;
         push(9'h01F, 1'b0);
         start_len(n);
         chk(n, rates[i].len);
         repeat (8 * n + 20) @(negedge mclk);
      end
      do_reset;
      cfg(2'h0, 16'h0001, 1'b1, 1'b0);
      @(negedge mclk);
      chk({sck_oe, sck_out}, 2'h3);
      // Each format sent, captured, then received back
      foreach (fmts[i]) begin
         @(negedge mclk);
         {char_len, mode9, msb_first, parity_type, stop_bits} = fmts[i][18:10];
         nb = fmts[i].m9 ? 9 : 5 + fmts[i].cl;
         n = mk(fmts[i], nb, v);
         push(fmts[i].d, fmts[i].am);
         remote.grab(n, got, ok);
         chk({ok, got}, {1'b1, v});
         remote.send(v, n, 1);
         take(fmts[i].d & (9'h1FF >> (9 - nb)), fmts[i].am);
      end
      // Bad parity, then bad stop bit
      e = '{2'h3, 1'b0, 1'b0, 3'h0, 2'h0, 9'h0A5, 1'b0};
      @(negedge mclk);
      {char_len, mode9, msb_first, parity_type, stop_bits} = e[18:10];
      n = mk(e, 8, v);
      remote.send(v ^ 14'h0200, n, 1);
      repeat (3) @(negedge mclk);
      chk({parity_err, frame_err}, 2'h2);
      clr;
      chk({parity_err, frame_err}, 2'h0);
      remote.send(v ^ 14'h0400, n, 1);
      repeat (3) @(negedge mclk);
      chk({parity_err, frame_err}, 2'h1);
      clr;
      // Two characters unread, then an idle line
      timeout_val = 8'h04;
      remote.send(v, n, 1);
      chk(rx_timeout, 0);
      remote.send(v, n, 1);
      repeat (3) @(negedge mclk);
      chk({overrun_err, rx_data}, {1'b1, 9'h0A5});
      repeat (12) @(negedge mclk);
      chk(rx_timeout, 1);
      clr;
      // Flow control holds four queued words until clear to send
      {handshake_en, dma_en, parity_type} = {2'h3, ubfc_pkg::PAR_NONE};
      @(negedge mclk);
      chk({rts_n, tx_dma_req}, 2'h1);
      for (int i = 1; i < 5; i++) push(9'(i), 1'b0);
      @(negedge mclk);
      chk({tx_ready, tx_dma_req}, 2'h0);
      {tx_valid, tx_data} = {1'b1, 9'h0FF};
      repeat (30) @(negedge mclk);
      tx_valid = 1'b0;
      chk({txd_out, tx_ready}, 2'h2);
      cts_n = 1'b0;
      for (int i = 1; i < 5; i++) begin
         remote.grab(10, got, ok);
         chk({ok, got[8:1]}, {1'b1, 8'(i)});
      end
      start_len(n);
      chk(n, 0);
      for (int i = 0; i < 2; i++) begin
         {handshake_en, rts_request} = 2'(i);
         @(negedge mclk);
         chk(rts_n, i == 0);
      end
      {ring_indicator_in_n, carrier_detect_in_n} = 2'h0;
      @(negedge mclk);
      chk({ring_indicator, carrier_detect}, 2'h3);
      // Echo and remote loop copy the receive line one clock late
      for (int m = 1; m < 4; m += 2) begin
         chan_mode = 2'(m);
         fork
            remote.send(14'h0, 1, 4);
            begin
               repeat (2) @(negedge mclk);
               chk(txd_out, 0);
            end
         join
         @(negedge mclk);
         chk(txd_out, 1);
         repeat (12) @(negedge mclk);
         clr;
      end
      // Local loop, clock stopped in mid-frame then resumed
      chan_mode = ubfc_pkg::CH_LOCAL;
      push(9'h055, 1'b0);
      repeat (3) @(negedge mclk);
      periph_en = 1'b0;
      repeat (30) @(negedge mclk);
      chk({txd_out, rx_valid}, 2'h2);
      periph_en = 1'b1;
      take(9'h055, 1'b0);
      wrap_up;
   end
endmodule // usart_baud_and_frame_core_test
